// File: serial_flash_link_modes.sv
// Serial flash link front end: single, dual, quad, quad command and DTR
`timescale 1ns/1ps
// Notes on behaviour
// - Single mode samples input line on rising edge
// - Read and status data leave on output line
// - Clock modes zero-zero and one-one both work
// - Byte 35h enters quad command mode
// - Quad command mode uses all four lines bidirectionally
// - Byte F5h leaves quad command mode
// - Power-on and 66h-99h reset return link to single mode; pin reset cannot fire in quad command mode
// - Quad command mode takes instruction in two clocks
// - DTR reads move address and data on both edges
// - Dual and quad commands move two or four bits
// - Three or four address bytes by mode or command
// - Program accepts one to 256 bytes per page
// - Erase by 4K sector, 32K, 64K block, chip
// - Read wrap burst of 8, 16, 32, 64 bytes
// - Shared pin is pause or reset, pause default
module serial_flash_link_modes #(
    parameter int DUMMY_CYCLES = flash_link_pkg::DUMMY_CYCLES_DEFAULT
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic en_i,
    // Link pins from the host
    input wire logic sclk_i,
    input wire logic cs_n_i,
    // Four data lines: input, output, enable (low drives)
    input wire logic [3:0] quad_line_i,
    output logic [3:0] quad_line_o,
    output logic [3:0] quad_line_oe_n_o,
    // Array side
    input wire logic [7:0] rd_data_i,
    input wire logic [7:0] status_i,
    output logic [31:0] rd_addr_o,
    output flash_link_pkg::link_evt_t evt_o,
    // Mode state
    output logic quad_command_mode_o,
    output logic addr4_mode_o,
    output logic pin_function_select_o
);
    flash_link_pkg::link_state_t s_reg;
    flash_link_pkg::link_state_t s_next;
    logic [5:0] sync_q;
    logic [5:0] sync_rise;
    logic [5:0] sync_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_high;
    logic [3:0] line_q;
    logic quad_busy;
    logic hold_active;
    logic hw_reset;

    // All link pins come from the host's domain
    edge_sync #(.W(6)) pin_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .en_i(en_i),
        .d_i({quad_line_i, cs_n_i, sclk_i}),
        .q_o(sync_q),
        .rise_o(sync_rise),
        .fall_o(sync_fall)
    );

    assign sclk_rise = sync_rise[0];
    assign sclk_fall = sync_fall[0];
    assign cs_high = sync_q[1];
    assign line_q = sync_q[5:2];

    // Line 3 is data whenever a four-lane transfer is under way
    assign quad_busy = s_reg.quad_command_mode || ((s_reg.ph != flash_link_pkg::PH_CMD) &&
        ((s_reg.info.addr_lanes == 3'd4) || (s_reg.info.data_lanes == 3'd4)));
    assign hold_active = !quad_busy && !cs_high && !line_q[3] &&
        !s_reg.rparam[flash_link_pkg::RP_PIN_FN_BIT];
    assign hw_reset = !quad_busy && !line_q[3] &&
        s_reg.rparam[flash_link_pkg::RP_PIN_FN_BIT];

    // Shift in 1, 2 or 4 bits; line 0 is the single-mode input
    function automatic logic [31:0] shift_in(input logic [31:0] sr,
                                             input logic [2:0] lanes,
                                             input logic [3:0] ln);
        case (lanes)
            3'd2: return {sr[29:0], ln[1:0]};
            3'd4: return {sr[27:0], ln};
            default: return {sr[30:0], ln[0]};
        endcase
    endfunction

    // Next read address, wrapping inside the burst window when enabled
    function automatic logic [31:0] next_rd(input logic [31:0] a,
                                            input logic [7:0] rp);
        logic [6:0] m;
        logic [31:0] inc;
        logic [31:0] mask;
        m = 7'((7'(flash_link_pkg::BURST_MIN_BYTES)
              << rp[flash_link_pkg::RP_BURST_LSB +: 2]) - 7'd1);
        inc = a + 32'h0000_0001;
        mask = {25'h0, m};
        if (rp[flash_link_pkg::RP_WRAP_EN_BIT]) begin
            return (a & ~mask) | (inc & mask);
        end
        return inc;
    endfunction

    // Protocol engine
    always_comb begin
        logic [2:0] lanes;
        logic [31:0] sh;
        logic [5:0] cnt_add;
        logic [7:0] byte_out;
        logic abits32;
        flash_link_pkg::cmd_info_t ci;
        s_next = s_reg;
        s_next.evt.cmd_valid = 1'b0;
        s_next.evt.wr_valid = 1'b0;
        s_next.evt.erase_valid = 1'b0;
        ci = flash_link_pkg::decode(s_reg.sr[7:0]);
        case (s_reg.ph)
            flash_link_pkg::PH_CMD: lanes = s_reg.quad_command_mode ? 3'd4 : 3'd1;
            flash_link_pkg::PH_ADDR: lanes = s_reg.info.addr_lanes;
            default: lanes = s_reg.info.data_lanes;
        endcase
        sh = shift_in(s_reg.sr, lanes, line_q);
        cnt_add = s_reg.cnt + {3'd0, lanes};
        abits32 = s_reg.addr4 || s_reg.info.force4;
        byte_out = s_reg.out_sr;
        if (cs_high) begin
            // Deselect aborts any frame and frees the lines
            s_next.ph = flash_link_pkg::PH_CMD;
            s_next.cnt = '0;
            s_next.line_oe_n = '1;
        end else if (hold_active) begin
            s_next.line_oe_n = '1; // Paused: clock edges ignored
        end else begin
            case (s_reg.ph)
                flash_link_pkg::PH_CMD: begin
                    // Rising edge only, so mode 3's leading fall is harmless
                    if (sclk_rise) begin
                        s_next.sr = sh;
                        s_next.cnt = cnt_add;
                        if (cnt_add == 6'd8) begin
                            ci = flash_link_pkg::decode(sh[7:0]);
                            if (s_reg.quad_command_mode) begin
                                ci.addr_lanes = 3'd4;
                                ci.data_lanes = 3'd4;
                            end
                            s_next.info = ci;
                            s_next.cnt = '0;
                            s_next.out_cnt = '0;
                            s_next.evt.cmd_valid = 1'b1;
                            s_next.evt.cmd = sh[7:0];
                            s_next.rst_armed =
                                (sh[7:0] == flash_link_pkg::CMD_RESET_ARM);
                            s_next.ph = flash_link_pkg::PH_SKIP;
                            case (ci.op)
                                flash_link_pkg::OP_READ,
                                flash_link_pkg::OP_PROG:
                                    s_next.ph = flash_link_pkg::PH_ADDR;
                                flash_link_pkg::OP_ERASE: begin
                                    if (ci.has_addr) begin
                                        s_next.ph = flash_link_pkg::PH_ADDR;
                                    end else begin
                                        s_next.evt.erase_valid = 1'b1;
                                        s_next.evt.erase_kind = ci.er;
                                    end
                                end
                                flash_link_pkg::OP_STATUS,
                                flash_link_pkg::OP_RP_RD:
                                    s_next.ph = flash_link_pkg::PH_DOUT;
                                flash_link_pkg::OP_RP_WR:
                                    s_next.ph = flash_link_pkg::PH_DIN;
                                default: begin
                                    if (!s_reg.quad_command_mode && sh[7:0] ==
                                        flash_link_pkg::CMD_QUAD_ENTER) begin
                                        s_next.quad_command_mode = 1'b1;
                                    end
                                    if (s_reg.quad_command_mode && sh[7:0] ==
                                        flash_link_pkg::CMD_QUAD_EXIT) begin
                                        s_next.quad_command_mode = 1'b0;
                                    end
                                    if (sh[7:0] == flash_link_pkg::CMD_ADDR4_ENTER) begin
                                        s_next.addr4 = 1'b1;
                                    end
                                    if (sh[7:0] == flash_link_pkg::CMD_ADDR4_EXIT) begin
                                        s_next.addr4 = 1'b0;
                                    end
                                    if (s_reg.rst_armed && sh[7:0] ==
                                        flash_link_pkg::CMD_RESET_GO) begin
                                        s_next.quad_command_mode = 1'b0;
                                        s_next.addr4 = 1'b0;
                                        s_next.rparam = flash_link_pkg::RP_RESET;
                                    end
                                end
                            endcase
                        end
                    end
                end
                flash_link_pkg::PH_ADDR: begin
                    // DTR takes address bits on both edges
                    if (sclk_rise || (s_reg.info.ddr && sclk_fall)) begin
                        s_next.sr = sh;
                        s_next.cnt = cnt_add;
                        if (cnt_add == (abits32 ? 6'(flash_link_pkg::ADDR4_BITS)
                                        : 6'(flash_link_pkg::ADDR3_BITS))) begin
                            s_next.addr = abits32 ? sh : {8'h00, sh[23:0]};
                            s_next.cnt = '0;
                            case (s_reg.info.op)
                                flash_link_pkg::OP_READ:
                                    s_next.ph = s_reg.info.dummy ?
                                        flash_link_pkg::PH_DUMMY :
                                        flash_link_pkg::PH_DOUT;
                                flash_link_pkg::OP_PROG:
                                    s_next.ph = flash_link_pkg::PH_DIN;
                                default: begin
                                    s_next.evt.erase_valid = 1'b1;
                                    s_next.evt.erase_kind = s_reg.info.er;
                                    s_next.evt.addr = s_next.addr;
                                    s_next.ph = flash_link_pkg::PH_SKIP;
                                end
                            endcase
                        end
                    end
                end
                flash_link_pkg::PH_DUMMY: begin
                    if (sclk_rise) begin
                        s_next.cnt = s_reg.cnt + 6'd1;
                        if (s_reg.cnt + 6'd1 == 6'(DUMMY_CYCLES)) begin
                            s_next.ph = flash_link_pkg::PH_DOUT;
                        end
                    end
                end
                flash_link_pkg::PH_DIN: begin
                    if (sclk_rise) begin
                        s_next.sr = sh;
                        s_next.cnt = cnt_add;
                        if (cnt_add == 6'd8) begin
                            s_next.cnt = '0;
                            if (s_reg.info.op == flash_link_pkg::OP_PROG) begin
                                s_next.evt.wr_valid = 1'b1;
                                s_next.evt.wr_data = sh[7:0];
                                s_next.evt.addr = s_reg.addr;
                                // Stay in the page: byte 257 overwrites byte 1
                                s_next.addr = {s_reg.addr[31:8],
                                               s_reg.addr[7:0] + 8'h01};
                            end else begin
                                s_next.rparam = sh[7:0];
                                s_next.ph = flash_link_pkg::PH_SKIP;
                            end
                        end
                    end
                end
                flash_link_pkg::PH_DOUT: begin
                    // Launch on falling edge; DTR launches on both
                    if (sclk_fall || (s_reg.info.ddr && sclk_rise)) begin
                        if (s_reg.out_cnt == 4'd0) begin
                            case (s_reg.info.op)
                                flash_link_pkg::OP_STATUS: byte_out = status_i;
                                flash_link_pkg::OP_RP_RD: byte_out = s_reg.rparam;
                                default: begin
                                    byte_out = rd_data_i;
                                    s_next.addr = next_rd(s_reg.addr,
                                                          s_reg.rparam);
                                end
                            endcase
                        end
                        s_next.line_oe_n = '1;
                        case (s_reg.info.data_lanes)
                            3'd2: begin
                                s_next.line_out[1:0] = byte_out[7:6];
                                s_next.line_oe_n[1:0] = 2'b00;
                            end
                            3'd4: begin
                                s_next.line_out = byte_out[7:4];
                                s_next.line_oe_n = 4'h0;
                            end
                            default: begin
                                s_next.line_out[1] = byte_out[7];
                                s_next.line_oe_n[1] = 1'b0;
                            end
                        endcase
                        s_next.out_sr = 8'(byte_out << s_reg.info.data_lanes);
                        s_next.out_cnt = ((s_reg.out_cnt == 4'd0) ? 4'd8 :
                            s_reg.out_cnt) - {1'b0, s_reg.info.data_lanes};
                    end
                end
                default: s_next.line_oe_n = '1;
            endcase
        end
        if (hw_reset) begin
            s_next.quad_command_mode = 1'b0;
            s_next.addr4 = 1'b0;
            s_next.ph = flash_link_pkg::PH_SKIP;
            s_next.line_oe_n = '1;
        end
    end

    // Single state register; power-on reset lands in single mode
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_reg <= '0;
            s_reg.line_oe_n <= '1;
            s_reg.rparam <= flash_link_pkg::RP_RESET;
        end else if (en_i) begin
            s_reg <= s_next;
        end
    end

    assign quad_line_o = s_reg.line_out;
    assign quad_line_oe_n_o = s_reg.line_oe_n;
    assign rd_addr_o = s_reg.addr;
    assign evt_o = s_reg.evt;
    assign quad_command_mode_o = s_reg.quad_command_mode;
    assign addr4_mode_o = s_reg.addr4;
    assign pin_function_select_o =
        s_reg.rparam[flash_link_pkg::RP_PIN_FN_BIT];
endmodule

// File: flash_link_pkg.sv
// Shared constants, command decode and carrier types for the flash link
package flash_link_pkg;

    // Command bytes that change link state
    localparam logic [7:0] CMD_QUAD_ENTER = 8'h35;
    localparam logic [7:0] CMD_QUAD_EXIT = 8'hf5;
    localparam logic [7:0] CMD_RESET_ARM = 8'h66;
    localparam logic [7:0] CMD_RESET_GO = 8'h99;
    localparam logic [7:0] CMD_ADDR4_ENTER = 8'hb7;
    localparam logic [7:0] CMD_ADDR4_EXIT = 8'h29;

    // Geometry and field positions
    localparam int ADDR3_BITS = 24;
    localparam int ADDR4_BITS = 32;
    localparam int PAGE_BYTES = 256;
    localparam int SECTOR_BYTES = 4096;
    localparam int BLOCK32_BYTES = 32768;
    localparam int BLOCK64_BYTES = 65536;
    localparam int BURST_MIN_BYTES = 8;
    localparam int RP_BURST_LSB = 0;
    localparam int RP_WRAP_EN_BIT = 4;
    localparam int RP_PIN_FN_BIT = 7;
    localparam logic [7:0] RP_RESET = 8'h00;
    localparam int DUMMY_CYCLES_DEFAULT = 8;

    typedef enum logic [2:0] {
        OP_CTRL, OP_READ, OP_PROG, OP_ERASE, OP_STATUS, OP_RP_WR, OP_RP_RD
    } op_t;

    typedef enum logic [1:0] {ER_SECTOR, ER_BLK32, ER_BLK64, ER_CHIP} erase_t;

    typedef enum logic [2:0] {
        PH_CMD, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_SKIP
    } phase_t;

    typedef struct packed {
        op_t op;
        logic has_addr;
        logic force4;
        logic [2:0] addr_lanes;
        logic [2:0] data_lanes;
        logic dummy;
        logic ddr;
        erase_t er;
    } cmd_info_t;

    typedef struct packed {
        logic cmd_valid;
        logic [7:0] cmd;
        logic wr_valid;
        logic [7:0] wr_data;
        logic erase_valid;
        erase_t erase_kind;
        logic [31:0] addr;
    } link_evt_t;

    typedef struct packed {
        phase_t ph;
        cmd_info_t info;
        logic quad_command_mode;
        logic addr4;
        logic rst_armed;
        logic [7:0] rparam;
        logic [31:0] sr;
        logic [5:0] cnt;
        logic [31:0] addr;
        logic [7:0] out_sr;
        logic [3:0] out_cnt;
        logic [3:0] line_out;
        logic [3:0] line_oe_n;
        link_evt_t evt;
    } link_state_t;

    // Opcode to transfer shape; anything unknown is a plain control byte
    function automatic cmd_info_t decode(input logic [7:0] c);
        cmd_info_t i;
        i = '{op: OP_CTRL, has_addr: 1'b0, force4: 1'b0, addr_lanes: 3'd1,
              data_lanes: 3'd1, dummy: 1'b0, ddr: 1'b0, er: ER_SECTOR};
        case (c)
            8'h03, 8'h13, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h3b, 8'h3c, 8'h6b,
            8'h6c, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'heb, 8'hec, 8'hed,
            8'hee: i.op = OP_READ;
            8'h02, 8'h12, 8'h32, 8'h34: i.op = OP_PROG;
            8'h20, 8'hd7, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7,
            8'h60: i.op = OP_ERASE;
            8'h05: i.op = OP_STATUS;
            8'hc0, 8'h63, 8'h65: i.op = OP_RP_WR;
            8'h61: i.op = OP_RP_RD;
            default: i.op = OP_CTRL;
        endcase
        i.has_addr = (i.op == OP_READ) || (i.op == OP_PROG) ||
                     ((i.op == OP_ERASE) && (c != 8'hc7) && (c != 8'h60));
        case (c)
            8'h13, 8'h0c, 8'h0e, 8'h3c, 8'h6c, 8'hbc, 8'hbe, 8'hec, 8'hee,
            8'h12, 8'h34, 8'h21, 8'h5c, 8'hdc: i.force4 = 1'b1;
            default: i.force4 = 1'b0;
        endcase
        i.dummy = (i.op == OP_READ) && (c != 8'h03) && (c != 8'h13);
        i.ddr = (c == 8'h0d) || (c == 8'h0e) || (c == 8'hbd) ||
                (c == 8'hbe) || (c == 8'hed) || (c == 8'hee);
        case (c)
            8'hbb, 8'hbc, 8'hbd, 8'hbe: i.addr_lanes = 3'd2;
            8'heb, 8'hec, 8'hed, 8'hee: i.addr_lanes = 3'd4;
            default: i.addr_lanes = 3'd1;
        endcase
        case (c)
            8'h3b, 8'h3c, 8'hbb, 8'hbc, 8'hbd, 8'hbe: i.data_lanes = 3'd2;
            8'h6b, 8'h6c, 8'heb, 8'hec, 8'hed, 8'hee, 8'h32,
            8'h34: i.data_lanes = 3'd4;
            default: i.data_lanes = 3'd1;
        endcase
        case (c)
            8'h52, 8'h5c: i.er = ER_BLK32;
            8'hd8, 8'hdc: i.er = ER_BLK64;
            8'hc7, 8'h60: i.er = ER_CHIP;
            default: i.er = ER_SECTOR;
        endcase
        return i;
    endfunction

endpackage

// File: edge_sync.sv
// Two-stage input synchroniser with rise and fall detection per bit
`timescale 1ns/1ps
module edge_sync #(
    parameter int W = 6
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic en_i,
    // Asynchronous inputs
    input wire logic [W-1:0] d_i,
    // Synchronised level and edges
    output logic [W-1:0] q_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] last_reg;

    // First stage feeds only the second stage
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else if (en_i) begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // Edges compare settled stages only
    assign q_o = sync_reg;
    assign rise_o = sync_reg & ~last_reg;
    assign fall_o = ~sync_reg & last_reg;
endmodule

// File: serial_flash_link_modes_monitor.sv
// Port assertions for the flash link front end
`timescale 1ns/1ps
module serial_flash_link_modes_monitor (
    // Clock, reset, select
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic cs_n_i,
    // Outputs watched
    input wire logic [3:0] quad_line_oe_n_o,
    input flash_link_pkg::link_evt_t evt_o,
    input wire logic quad_command_mode_o,
    input wire logic addr4_mode_o,
    input wire logic pin_function_select_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // Completed instruction byte of a given value
    sequence s_cmd(logic [7:0] c);
        evt_o.cmd_valid && evt_o.cmd == c;
    endsequence
    sequence s_desel;
        cs_n_i [*6];
    endsequence
    property p_quad_on;
        s_cmd(flash_link_pkg::CMD_QUAD_ENTER) |-> ##[0:3] quad_command_mode_o;
    endproperty
    property p_quad_off;
        s_cmd(flash_link_pkg::CMD_QUAD_EXIT) |-> ##[0:3] !quad_command_mode_o;
    endproperty
    property p_a4_on;
        s_cmd(flash_link_pkg::CMD_ADDR4_ENTER) |-> ##[0:3] addr4_mode_o;
    endproperty
    property p_a4_off;
        s_cmd(flash_link_pkg::CMD_ADDR4_EXIT) |-> ##[0:3] !addr4_mode_o;
    endproperty
    property p_rst_modes;
        $fell(sys_rst_i) |-> !quad_command_mode_o && !addr4_mode_o &&
            !pin_function_select_o && quad_line_oe_n_o == 4'hf;
    endproperty
    property p_cmd_pulse;
        evt_o.cmd_valid |=> !evt_o.cmd_valid;
    endproperty
    property p_wr_pulse;
        evt_o.wr_valid |=> !evt_o.wr_valid;
    endproperty
    property p_idle_oe;
        s_desel |-> quad_line_oe_n_o == 4'hf;
    endproperty
    property p_idle_evt;
        s_desel |-> !evt_o.cmd_valid && !evt_o.wr_valid;
    endproperty
    a_quad_on: assert property (p_quad_on)
        else $error("quad mode not entered");
    a_quad_off: assert property (p_quad_off)
        else $error("quad mode not left");
    a_a4_on: assert property (p_a4_on)
        else $error("4-byte mode not entered");
    a_a4_off: assert property (p_a4_off)
        else $error("4-byte mode not left");
    a_rst_modes: assert property (p_rst_modes)
        else $error("modes not cleared by reset");
    a_cmd_pulse: assert property (p_cmd_pulse)
        else $error("command pulse too long");
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write pulse too long");
    a_idle_oe: assert property (p_idle_oe)
        else $error("line driven while deselected");
    a_idle_evt: assert property (p_idle_evt)
        else $error("event while deselected");
endmodule

// File: flash_host_model.sv
// Behavioural host controller driving the flash link pins
`timescale 1ns/1ps
module flash_host_model (
    // Resolved line levels
    input wire logic [3:0] line_i,
    // Host pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic [3:0] line_o,
    output logic [3:0] drv_o
);
    bit cpol;
    // Deselected with lines released at start
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        line_o = 4'hf;
        drv_o = 4'h0;
    end
    // Clock parks at its idle level before select falls
    task automatic start(input bit m3);
        cpol = m3;
        sclk_o = m3;
        #80 cs_n_o = 1'b0;
    endtask
    // Data set after the fall, device takes it on the rise
    task automatic xfer(input logic [7:0] tx, input int ln,
                        output logic [7:0] rx);
        for (int i = 7; i >= 0; i -= ln) begin
            sclk_o = 1'b0;
            drv_o = (ln == 4) ? 4'hf : 4'h1;
            line_o = (ln == 4) ? tx[i -: 4] : {3'h7, tx[i]};
            #80 sclk_o = 1'b1;
            #80 rx = {rx[6:0], line_i[1]};
        end
    endtask
    // Final fall only in mode zero, then deselect and release
    task automatic stop();
        if (!cpol) sclk_o = 1'b0;
        #80 cs_n_o = 1'b1;
        drv_o = 4'h0;
        #240;
    endtask
    // Clock activity with select high, must be ignored
    task automatic stray();
        repeat (8) #80 sclk_o = ~sclk_o;
    endtask
endmodule

// File: serial_flash_link_modes_test.sv
// Self-checking bench for the flash link front end
`timescale 1ns/1ps
module serial_flash_link_modes_test;
    logic mclk_i, sys_rst_i, en_i, sclk, cs_n, qm, a4m, pfs;
    logic [3:0] hl, hdrv, dl, doe_n, ql;
    logic [7:0] rd_data_i, status_i, rx, last_cmd, last_wd;
    logic [7:0] ops [4] = '{8'h20, 8'h52, 8'hd8, 8'hc7};
    logic [31:0] rd_addr_o, last_addr, a;
    flash_link_pkg::link_evt_t evt_o;
    flash_link_pkg::erase_t last_er;
    int err_count = 0, n_tests = 0, n_cmd = 0, n_wr = 0, n;
    serial_flash_link_modes u_serial_flash_link_modes (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .en_i(en_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .quad_line_i(ql), .quad_line_o(dl), .quad_line_oe_n_o(doe_n),
        .rd_data_i(rd_data_i), .status_i(status_i), .rd_addr_o(rd_addr_o),
        .evt_o(evt_o), .quad_command_mode_o(qm), .addr4_mode_o(a4m),
        .pin_function_select_o(pfs));
    flash_host_model u_flash_host_model (.line_i(ql), .sclk_o(sclk),
        .cs_n_o(cs_n), .line_o(hl), .drv_o(hdrv));
    // Pull-ups on every line nobody drives
    always_comb for (int k = 0; k < 4; k++)
        ql[k] = !doe_n[k] ? dl[k] : (hdrv[k] ? hl[k] : 1'b1);
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    function automatic logic [7:0] exp_rd(input logic [31:0] ad);
        return ad[7:0] ^ 8'h5a;
    endfunction
    // Array content follows the address
    always @(negedge mclk_i) rd_data_i <= exp_rd(rd_addr_o);
    // Record the latest events
    always @(posedge mclk_i) begin
        if (evt_o.cmd_valid) begin
            last_cmd <= evt_o.cmd;
            n_cmd <= n_cmd + 1;
        end
        if (evt_o.wr_valid) begin
            last_wd <= evt_o.wr_data;
            last_addr <= evt_o.addr;
            n_wr <= n_wr + 1;
        end
        if (evt_o.erase_valid) begin
            last_er <= evt_o.erase_kind;
            last_addr <= evt_o.addr;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One framed command: opcode, address bytes, data bytes
    task automatic frame(input bit m3, input logic [7:0] op, input int ln,
        input logic [31:0] ad, input int nab, input int nd,
        input logic [7:0] wd);
        u_flash_host_model.start(m3);
        u_flash_host_model.xfer(op, ln, rx);
        for (int k = nab - 1; k >= 0; k--)
            u_flash_host_model.xfer(ad[k*8 +: 8], 1, rx);
        repeat (nd) u_flash_host_model.xfer(wd, 1, rx);
        u_flash_host_model.stop();
    endtask
    initial begin
        #1000000;
        err_count++;
        end_sim();
    end
    initial begin
        sys_rst_i = 1'b1;
        en_i = 1'b1;
        status_i = 8'h00;
        a = $urandom(32'h96b1);
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i) sys_rst_i = 1'b0;
        check({qm, a4m, pfs, doe_n}, 7'h0f);
        #100;
        a = $urandom;
        frame(0, 8'h03, 1, a, 3, 1, 8'h00);
        check(last_cmd, 8'h03);
        check(rx, exp_rd(a));
        @(negedge mclk_i) status_i = 8'($urandom);
        frame(1, 8'h05, 1, 0, 0, 1, 8'h00);
        check(rx, status_i);
        // Last byte of a page, second byte must wrap
        a = {8'h00, a[23:8], 8'hff};
        frame(0, 8'h02, 1, a, 3, 2, a[15:8]);
        check(n_wr, 2);
        check(last_addr, {a[31:8], 8'h00});
        check(last_wd, a[15:8]);
        foreach (ops[k]) begin
            frame(0, ops[k], 1, a, (k == 3) ? 0 : 3, 0, 8'h00);
            check(last_er, k);
        end
        frame(0, 8'hb7, 1, 0, 0, 0, 8'h00);
        check(a4m, 1);
        a = $urandom;
        frame(0, 8'h20, 1, a, 4, 0, 8'h00);
        check(last_addr, a);
        frame(0, 8'h29, 1, 0, 0, 0, 8'h00);
        check(a4m, 0);
        n = n_cmd;
        u_flash_host_model.stray();
        #400;
        check(n_cmd, n);
        frame(0, 8'h35, 1, 0, 0, 0, 8'h00);
        check(qm, 1);
        frame(0, 8'hf5, 4, 0, 0, 0, 8'h00);
        check(last_cmd, 8'hf5);
        check(qm, 0);
        frame(0, 8'hc0, 1, 0, 0, 1, 8'h80);
        check(pfs, 1);
        frame(0, 8'h35, 1, 0, 0, 0, 8'h00);
        frame(0, 8'h66, 4, 0, 0, 0, 8'h00);
        frame(0, 8'h99, 4, 0, 0, 0, 8'h00);
        check(qm, 0);
        check(pfs, 0);
        end_sim();
    end
endmodule
bind serial_flash_link_modes serial_flash_link_modes_monitor u_mon (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i),
    .quad_line_oe_n_o(quad_line_oe_n_o), .evt_o(evt_o),
    .quad_command_mode_o(quad_command_mode_o), .addr4_mode_o(addr4_mode_o),
    .pin_function_select_o(pin_function_select_o));
